// [hw/dual_quadrature_decoder.sv]
// two-channel quadrature decoder with wishbone register access
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
module dual_quadrature_decoder
  import quad_decoder_pkg::*;
  #(
    parameter int FILT_LEN = FILT_TICKS                // filter depth in sample ticks
  )
  (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [31:0]       wb_dat_i,
    input  wire logic [3:0]        wb_sel_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic [7:0]        port_i,
    input  wire logic              decoder_sample_tick_i,
    output logic                   irq_o,
    output logic      [1:0]        irq_level_o
  );

  // pin synchroniser; first stage feeds only the second
  logic [7:0] sync1_reg;                              // first stage
  logic [7:0] sync2_reg;                              // safe copy of the port

  // filter history and filtered port value
  logic [7:0] hist_reg  [FILT_LEN];
  logic [7:0] hist_next [FILT_LEN];
  logic [7:0] filt_reg;
  logic [7:0] filt_next;

  // channel state
  chan_s      chan_reg      [2];
  chan_s      chan_next     [2];
  logic [1:0] prev_reg      [2];                      // last sampled {i,q}
  logic [1:0] prev_next     [2];
  logic [1:0] seen_reg      [2];                      // select value at last tick
  logic [1:0] seen_next     [2];

  // software registers and bus answer
  logic [7:0]  cfg_reg;
  logic [7:0]  cfg_next;
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic        irq_reg;
  logic        irq_next;
  logic [1:0]  lvl_reg;
  logic [1:0]  lvl_next;

  // decoded bus terms
  logic       req;                                    // request taken this edge
  logic       wr_lane;                                // write with low byte enabled
  logic       status_rd;                              // read of status, clears flags
  logic [1:0] clr;                                    // counter reset strobes
  logic [1:0] sel      [2];                           // select field per channel
  logic [1:0] cur      [2];                           // present filtered {i,q}
  logic [1:0] step     [2];
  logic [1:0] set_up;
  logic [1:0] set_dn;
  logic [7:0] rd_byte;

  // pick {i,q} of a pair from the filtered port
  function automatic logic [1:0] pick(input logic [7:0] f, input logic [1:0] s,
                                      input int lo_q, input int hi_q);
    logic [1:0] r;
    r = (s == SEL_HIGH) ? {f[hi_q+1], f[hi_q]} : {f[lo_q+1], f[lo_q]};
    return r;
  endfunction

  // wishbone decode; single-cycle answer so a held request is taken once
  // the ack gate costs a dead cycle between requests, but a held strobe never clears flags twice
  always_comb
  begin
    req       = wb_cyc_i && wb_stb_i && !ack_reg;
    wr_lane   = req && wb_we_i && wb_sel_i[0];
    status_rd = req && !wb_we_i && (wb_adr_i == byte_addr(STATUS_IDX));
    clr[0]    = wr_lane && (wb_adr_i == byte_addr(STATUS_IDX)) && wb_dat_i[ST_C1_CLR];
    clr[1]    = wr_lane && (wb_adr_i == byte_addr(STATUS_IDX)) && wb_dat_i[ST_C2_CLR];
  end

  // input filter: a bit changes only after FILT_LEN agreeing tick samples
  // a deeper filter rejects wider glitches, at the price of more ticks of count latency
  always_comb
  begin
    logic all1;
    logic all0;
    all1      = 1'b0;
    all0      = 1'b0;
    hist_next = hist_reg;
    filt_next = filt_reg;
    if (decoder_sample_tick_i)
    begin
      hist_next[0] = sync2_reg;
      for (int k = 1; k < FILT_LEN; k++)
        hist_next[k] = hist_reg[k-1];
      for (int b = 0; b < 8; b++)
      begin
        all1 = 1'b1;
        all0 = 1'b1;
        for (int k = 0; k < FILT_LEN; k++)
        begin
          all1 = all1 & hist_next[k][b];
          all0 = all0 & ~hist_next[k][b];
        end
        if (all1)
          filt_next[b] = 1'b1;
        else if (all0)
          filt_next[b] = 1'b0;
      end
    end
  end

  // channel counters, wrap flags and select tracking
  // a disabled channel still follows its low pair, so its phase memory never goes stale
  always_comb
  begin
    sel[0] = cfg_reg[CFG_C1_LSB+1:CFG_C1_LSB];
    sel[1] = cfg_reg[CFG_C2_LSB+1:CFG_C2_LSB];
    cur[0] = pick(filt_reg, sel[0], C1_LOW_Q, C1_HIGH_Q);
    cur[1] = pick(filt_reg, sel[1], C2_LOW_Q, C2_HIGH_Q);
    for (int c = 0; c < 2; c++)
    begin
      chan_next[c] = chan_reg[c];
      prev_next[c] = prev_reg[c];
      seen_next[c] = seen_reg[c];
      step[c]      = STEP_NONE;
      // a select that changed since the last tick only resyncs the phase
      if (decoder_sample_tick_i)
      begin
        if (sel[c][1] && (sel[c] == seen_reg[c]))
          step[c] = quad_step(prev_reg[c], cur[c]);
        prev_next[c] = cur[c];
        seen_next[c] = sel[c];
      end
      set_up[c] = !clr[c] && (step[c] == STEP_UP) && (chan_reg[c].count == 8'hff);
      set_dn[c] = !clr[c] && (step[c] == STEP_DN) && (chan_reg[c].count == 8'h00);
      if (clr[c])
        chan_next[c].count = COUNT_RESET;
      else if (step[c] == STEP_UP)
        chan_next[c].count = chan_reg[c].count + 8'h01;
      else if (step[c] == STEP_DN)
        chan_next[c].count = chan_reg[c].count - 8'h01;
      // set beats a clearing read in the same cycle
      chan_next[c].wrap_up = set_up[c] | (chan_reg[c].wrap_up & ~status_rd);
      chan_next[c].wrap_dn = set_dn[c] | (chan_reg[c].wrap_dn & ~status_rd);
    end
  end

  // register writes, read mux and interrupt
  // read data is registered so that it stands for as long as the acknowledge does
  always_comb
  begin
    cfg_next = cfg_reg;
    if (wr_lane && (wb_adr_i == byte_addr(CONFIG_IDX)))
      cfg_next = wb_dat_i[7:0] & CFG_WR_MASK;
    rd_byte = 8'h00;                                                             // unmapped reads zero
    if (wb_adr_i == byte_addr(STATUS_IDX))
    begin
      rd_byte           = 8'h00;
      rd_byte[ST_C2_UP] = chan_reg[1].wrap_up;
      rd_byte[ST_C2_DN] = chan_reg[1].wrap_dn;
      rd_byte[ST_C1_UP] = chan_reg[0].wrap_up;
      rd_byte[ST_C1_DN] = chan_reg[0].wrap_dn;
    end
    else if (wb_adr_i == byte_addr(CONFIG_IDX))
      rd_byte = cfg_reg;
    else if (wb_adr_i == byte_addr(COUNT1_IDX))
      rd_byte = chan_reg[0].count;
    else if (wb_adr_i == byte_addr(COUNT2_IDX))
      rd_byte = chan_reg[1].count;
    ack_next = req;
    dat_next = (req && !wb_we_i) ? {24'h000000, rd_byte} : dat_reg;
    lvl_next = cfg_next[1:0];
    // level stays up while any flag stands and a priority is chosen
    irq_next = (lvl_next != 2'h0) &&
               (chan_next[0].wrap_up | chan_next[0].wrap_dn |
                chan_next[1].wrap_up | chan_next[1].wrap_dn);
  end

  // state registers
  // every top-level output is taken straight from one of these flip-flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // counters, flags and configuration start cleared, both channels off
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      filt_reg  <= 8'h00;
      for (int k = 0; k < FILT_LEN; k++)
        hist_reg[k] <= 8'h00;
      for (int c = 0; c < 2; c++)
      begin
        chan_reg[c] <= '{count: COUNT_RESET, wrap_up: 1'b0, wrap_dn: 1'b0};
        prev_reg[c] <= 2'h0;
        seen_reg[c] <= 2'h0;
      end
      cfg_reg <= CFG_RESET;
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
      irq_reg <= 1'b0;
      lvl_reg <= 2'h0;
    end
    else
    begin
      sync1_reg <= port_i;
      sync2_reg <= sync1_reg;
      filt_reg  <= filt_next;
      hist_reg  <= hist_next;
      chan_reg  <= chan_next;
      prev_reg  <= prev_next;
      seen_reg  <= seen_next;
      cfg_reg   <= cfg_next;
      ack_reg   <= ack_next;
      dat_reg   <= dat_next;
      irq_reg   <= irq_next;
      lvl_reg   <= lvl_next;
    end
  end

  assign wb_ack_o    = ack_reg;
  assign wb_dat_o    = dat_reg;
  assign irq_o       = irq_reg;
  assign irq_level_o = lvl_reg;

  // checks on the decoder behaviour
  default clocking dflt_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // all checks sit on the one clock and stay quiet while reset is held

  c2_wrap_up_a: assert property ((step[1] == STEP_UP) && (chan_reg[1].count == 8'hff) && !clr[1]
                                 |=> chan_reg[1].wrap_up && (chan_reg[1].count == 8'h00))
    else $error("channel two up-wrap flag missing");
  c2_wrap_dn_a: assert property ((step[1] == STEP_DN) && (chan_reg[1].count == 8'h00) && !clr[1]
                                 |=> chan_reg[1].wrap_dn && (chan_reg[1].count == 8'hff))
    else $error("channel two down-wrap flag missing");
  c1_wrap_up_a: assert property ((step[0] == STEP_UP) && (chan_reg[0].count == 8'hff) && !clr[0]
                                 |=> chan_reg[0].wrap_up && (chan_reg[0].count == 8'h00))
    else $error("channel one up-wrap flag missing");
  c1_wrap_dn_a: assert property ((step[0] == STEP_DN) && (chan_reg[0].count == 8'h00) && !clr[0]
                                 |=> chan_reg[0].wrap_dn && (chan_reg[0].count == 8'hff))
    else $error("channel one down-wrap flag missing");
  read_clears_a: assert property (status_rd && (set_up == 2'h0) && (set_dn == 2'h0)
                                  |=> !chan_reg[0].wrap_up && !chan_reg[0].wrap_dn &&
                                      !chan_reg[1].wrap_up && !chan_reg[1].wrap_dn && !irq_o)
    else $error("status read left a flag or interrupt set");
  zero_bits_a: assert property (status_rd |=> wb_ack_o && (wb_dat_o[5] == 1'b0) && (wb_dat_o[1] == 1'b0)
                                && (wb_dat_o[4] == 1'b0) && (wb_dat_o[0] == 1'b0))
    else $error("status reserved bits not zero");
  clear_two_a: assert property (clr[1] |=> (chan_reg[1].count == 8'h00) && !$rose(chan_reg[1].wrap_up)
                                && !$rose(chan_reg[1].wrap_dn))
    else $error("channel two reset failed");
  clear_one_a: assert property (clr[0] |=> (chan_reg[0].count == 8'h00) && !$rose(chan_reg[0].wrap_up)
                                && !$rose(chan_reg[0].wrap_dn))
    else $error("channel one reset failed");
  sel_change_a: assert property (decoder_sample_tick_i && (sel[0] != seen_reg[0]) && !clr[0]
                                 |=> $stable(chan_reg[0].count))
    else $error("select change moved channel one count");
  no_tick_a: assert property (!decoder_sample_tick_i && (clr == 2'h0)
                              |=> $stable(chan_reg[0].count) && $stable(chan_reg[1].count))
    else $error("count moved without a sample tick");
  count_read_a: assert property (req && !wb_we_i && (wb_adr_i == byte_addr(COUNT1_IDX))
                                 |=> wb_ack_o && (wb_dat_o[7:0] == $past(chan_reg[0].count)))
    else $error("channel one count read wrong");
  irq_tie_a: assert property (irq_o == ((irq_level_o != 2'h0) && (chan_reg[0].wrap_up |
                              chan_reg[0].wrap_dn | chan_reg[1].wrap_up | chan_reg[1].wrap_dn)))
    else $error("interrupt does not follow flags");

  // second channel and register checks
  sel_swap_two_a: assert property (decoder_sample_tick_i && (sel[1] != seen_reg[1]) && !clr[1]
                                   |=> $stable(chan_reg[1].count))
    else $error("select change moved channel two count");
  count_two_a: assert property (req && !wb_we_i && (wb_adr_i == byte_addr(COUNT2_IDX))
                                |=> wb_ack_o && (wb_dat_o[7:0] == $past(chan_reg[1].count)))
    else $error("channel two count read wrong");
  cfg_write_a: assert property (wr_lane && (wb_adr_i == byte_addr(CONFIG_IDX))
                                |=> (cfg_reg[5:4] == 2'h0) && (irq_level_o == cfg_reg[1:0]))
    else $error("configuration write kept ignored bits or gave a wrong level");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge stood longer than one cycle");

  // counting arithmetic and interrupt raising
  step_up_a: assert property ((step[0] == STEP_UP) && !clr[0]
                              |=> chan_reg[0].count == ($past(chan_reg[0].count) + 8'h01))
    else $error("channel one did not count up by one");
  step_down_a: assert property ((step[1] == STEP_DN) && !clr[1]
                                |=> chan_reg[1].count == ($past(chan_reg[1].count) - 8'h01))
    else $error("channel two did not count down by one");
  irq_sets_a: assert property (((set_up != 2'h0) || (set_dn != 2'h0)) && (cfg_next[1:0] != 2'h0)
                               |=> irq_o)
    else $error("wrap did not raise the interrupt");

  wrap_seen_c: cover property (set_up[0] ##[1:100] status_rd);
  down_wrap_c: cover property (set_dn[1]);
  reset_hit_c: cover property (clr[0] && (step[0] != STEP_NONE));
  sel_swap_c: cover property (decoder_sample_tick_i && (sel[0] != seen_reg[0]));
  clear_two_c: cover property (clr[1]);

endmodule // dual_quadrature_decoder

// [pkg/quad_decoder_pkg.sv]
// constants, types and helpers for the two-channel quadrature decoder
// Contract
// - channel two up-wrap sets status bit 7
// - channel two down-wrap sets status bit 6
// - channel one up-wrap sets status bit 3
// - channel one down-wrap sets status bit 2
// - wrap flags read-only, cleared by status read
// - status bits 5 and 1 read zero
// - write one bit 4 zeroes channel two
// - write one bit 0 zeroes channel one
// - config bits 7:6 pick channel two inputs
// - select changes never cause a count step
// - config bits 3:2 pick channel one inputs
// - config bits 5:4 ignored on write
// - config bits 1:0 give interrupt level
// - count registers return present counter values
// - interrupt rises with flags, status read clears
// - inputs filtered, pulses under two ticks rejected
// - sampling and counting advance only on tick
package quad_decoder_pkg;

  localparam int ADDR_W = 12;                       // word index times four fits in 12 bits

  // register indices; byte address is four times the index
  localparam logic [7:0] STATUS_IDX = 8'h90;
  localparam logic [7:0] CONFIG_IDX = 8'h91;
  localparam logic [7:0] COUNT1_IDX = 8'h94;
  localparam logic [7:0] COUNT2_IDX = 8'h96;

  // status/control bit positions
  localparam int ST_C2_UP  = 7;
  localparam int ST_C2_DN  = 6;
  localparam int ST_C2_CLR = 4;
  localparam int ST_C1_UP  = 3;
  localparam int ST_C1_DN  = 2;
  localparam int ST_C1_CLR = 0;

  // configuration field layout
  localparam int         CFG_C2_LSB   = 6;
  localparam int         CFG_C1_LSB   = 2;
  localparam logic [7:0] CFG_WR_MASK  = 8'hcf;      // bits 5:4 are dropped on write
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam logic [7:0] COUNT_RESET  = 8'h00;
  localparam logic [1:0] SEL_HIGH     = 2'h3;       // 10 low pair, 11 high pair, 0x off

  // port bit holding Q of each pair; I sits one bit above
  localparam int C1_LOW_Q  = 0;
  localparam int C1_HIGH_Q = 4;
  localparam int C2_LOW_Q  = 2;
  localparam int C2_HIGH_Q = 6;

  localparam int FILT_TICKS = 2;                    // samples that must agree before a change

  localparam logic [1:0] STEP_NONE = 2'h0;
  localparam logic [1:0] STEP_UP   = 2'h1;
  localparam logic [1:0] STEP_DN   = 2'h2;

  // per-channel counter and its wrap flags
  typedef struct packed {
    logic [7:0] count;
    logic       wrap_up;
    logic       wrap_dn;
  } chan_s;

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  // one quadrature step from previous to present {i,q}; double changes give none
  function automatic logic [1:0] quad_step(input logic [1:0] prev, input logic [1:0] cur);
    logic [1:0] r;
    r = STEP_NONE;
    unique case ({prev, cur})
      4'b0010, 4'b1011, 4'b1101, 4'b0100: r = STEP_UP;   // i leads q
      4'b0001, 4'b0111, 4'b1110, 4'b1000: r = STEP_DN;   // q leads i
      default:                            r = STEP_NONE;
    endcase
    return r;
  endfunction

endpackage

// [bench/quad_encoder_model.sv]
// behavioural model of the incremental shaft encoders on the shared input port
`timescale 1ns/1ps
module quad_encoder_model
  (
    input  wire logic       clk_i,
    output logic      [7:0] port_o
  );
  logic [1:0] pos_reg [4];  // binary position of each pin pair, turned into phases by iq

  // encoders start at rest with both phases low
  initial
  begin
    for (int p = 0; p < 4; p++) pos_reg[p] = 2'h0;
    port_o = 8'h00;
  end

  // in-phase leads quadrature when turning up: 00, 10, 11, 01
  function automatic logic [1:0] iq(input logic [1:0] g);
    return {g[0] ^ g[1], g[1]};
  endfunction

  // one detent; held long enough for sync, filter and decode to settle
  task automatic step(input int pair, input bit up);
    @(posedge clk_i);
    pos_reg[pair] = up ? pos_reg[pair] + 2'h1 : pos_reg[pair] - 2'h1;
    port_o[2*pair +: 2] <= iq(pos_reg[pair]);
    repeat (14) @(posedge clk_i);
  endtask

  // two-clock spike on the quadrature line: one tick period wide, so one sample sees it;
  // from phase 11 it would first step down and wrap a zero count if it got through
  task automatic spike(input int pair);
    @(posedge clk_i);
    port_o[2*pair] <= ~port_o[2*pair];
    repeat (2) @(posedge clk_i);
    port_o[2*pair] <= ~port_o[2*pair];
    repeat (14) @(posedge clk_i);
  endtask
endmodule  // quad_encoder_model

// [bench/tb.sv]
// self-checking bench for the dual quadrature decoder
`timescale 1ns/1ps
module tb;
  import quad_decoder_pkg::*;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              wb_cyc_i = 1'b0;
  logic              wb_stb_i = 1'b0;
  logic              wb_we_i = 1'b0;
  logic [ADDR_W-1:0] wb_adr_i = '0;
  logic [31:0]       wb_dat_i = 32'h0;
  logic [3:0]        wb_sel_i = 4'hf;
  logic [31:0]       wb_dat_o;
  logic              wb_ack_o;
  wire logic [7:0]   port_i;
  logic              tick = 1'b0;
  logic              irq_o;
  logic [1:0]        irq_level_o;
  int                err_count = 0;
  int                compares = 0;
  logic [32:0]       exp_q [$];  // check flag and expected read data
  logic [32:0]       e;
  logic [7:0]        cnt_exp [2] = '{8'h00, 8'h00};
  logic [7:0]        exp_st = 8'h00;
  logic [15:0]       lfsr = 16'h4e9c;

  always #5 clk_i = ~clk_i;

  // tick every second clock, half the fastest rate the decoder accepts
  always @(posedge clk_i) tick <= ~tick;

  dual_quadrature_decoder u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .port_i(port_i), .decoder_sample_tick_i(tick), .irq_o(irq_o),
    .irq_level_o(irq_level_o));
  quad_encoder_model enc (.clk_i(clk_i), .port_o(port_i));

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    compares++;
    if (seen !== expv)
    begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask

  // one classic cycle; the expectation is queued before the request
  task automatic acc(input bit we, input logic [7:0] idx, input logic [7:0] d, input bit c);
    exp_q.push_back({c, 24'h0, d});
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {2'h0, idx, 2'h0};
    wb_dat_i <= {24'h0, d};
    // no cycle count is assumed; only the watchdog ends a wait that never sees ack
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] d);
    acc(1'b0, idx, d, 1'b1);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    acc(1'b1, idx, d, 1'b0);
  endtask

  // turn channel c through n detents and note the wraps it must flag
  task automatic move(input int c, input int pair, input bit up, input int n);
    for (int i = 0; i < n; i++)
    begin
      enc.step(pair, up);
      if (up && cnt_exp[c] == 8'hff) exp_st[c ? ST_C2_UP : ST_C1_UP] = 1'b1;
      if (!up && cnt_exp[c] == 8'h00) exp_st[c ? ST_C2_DN : ST_C1_DN] = 1'b1;
      cnt_exp[c] = up ? cnt_exp[c] + 8'h01 : cnt_exp[c] - 8'h01;
    end
  endtask

  // read data is compared on the acknowledge edge, oldest note first
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && wb_cyc_i === 1'b1)
    begin
      e = exp_q.pop_front();
      if (e[32]) chk(wb_dat_o, e[31:0]);
    end

  task end_sim;
    $display("mismatches %0d comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // a hang is cut short well past the expected run length
  initial
  begin
    #300000;
    err_count++;
    end_sim();
  end

  initial
  begin
    int n;
    int pr;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(CONFIG_IDX, 8'h00);
    rd(STATUS_IDX, 8'h00);
    rd(COUNT1_IDX, 8'h00);
    rd(COUNT2_IDX, 8'h00);
    rd(8'h92, 8'h00);  // unmapped place reads zero
    wr(CONFIG_IDX, 8'h3c);
    rd(CONFIG_IDX, 8'h0c);
    for (int lv = 0; lv < 4; lv++)
    begin
      wr(CONFIG_IDX, 8'(lv));
      chk(32'(irq_level_o), 32'(lv));
    end
    // both selects per channel; level 0 on the low pairs keeps the line quiet
    for (int s = 2; s < 4; s++)
    begin
      wr(CONFIG_IDX, 8'((s << 6) | (s << 2) | (s - 2)));
      for (int c = 0; c < 2; c++)
      begin
        lfsr = lfsr_next(lfsr);
        n = 1 + int'(lfsr[2:0]);
        pr = 2 * (s - 2) + c;
        move(c, pr, 1'b0, n);
        chk(32'(irq_o), 32'(s == 3));
        rd(c ? COUNT2_IDX : COUNT1_IDX, cnt_exp[c]);
        rd(STATUS_IDX, exp_st);
        exp_st = 8'h00;
        chk(32'(irq_o), 32'h0);
        move(c, pr, 1'b1, n);
        rd(STATUS_IDX, exp_st);
        exp_st = 8'h00;
        rd(STATUS_IDX, 8'h00);
      end
    end
    // zero bits leave counters alone; ones zero them without a flag
    wr(CONFIG_IDX, 8'hb9);
    move(0, 0, 1'b1, 2);
    move(1, 1, 1'b1, 1);
    wr(STATUS_IDX, 8'hee);
    rd(COUNT1_IDX, 8'h02);
    rd(COUNT2_IDX, 8'h01);
    rd(STATUS_IDX, 8'h00);
    wr(STATUS_IDX, 8'h11);
    cnt_exp = '{8'h00, 8'h00};
    rd(COUNT1_IDX, 8'h00);
    rd(COUNT2_IDX, 8'h00);
    rd(STATUS_IDX, 8'h00);
    chk(32'(irq_o), 32'h0);
    enc.spike(0);
    rd(COUNT1_IDX, 8'h00);
    rd(STATUS_IDX, 8'h00);
    // pairs now sit at different phases: switching must not step
    move(0, 0, 1'b1, 1);
    wr(CONFIG_IDX, 8'hbd);
    wr(CONFIG_IDX, 8'hb1);
    wr(CONFIG_IDX, 8'hb9);
    repeat (20) @(posedge clk_i);
    rd(COUNT1_IDX, 8'h01);
    rd(STATUS_IDX, 8'h00);
    end_sim();
  end
endmodule  // tb
